// ===== logic/smrc_top.sv
`timescale 1ns/10ps
`default_nettype none
module smrc_top (
    input wire logic SYS_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [smrc_pkg::ADDR_W-1:0] PADDR_IN,
    input wire logic [smrc_pkg::DATA_W-1:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    output logic [smrc_pkg::DATA_W-1:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic WAKE_IRQ_IN,
    output logic CPU_CLK_EN_OUT,
    output logic IO_CLK_EN_OUT,
    output logic INTR_EN_OUT,
    output logic ADC_CLK_EN_OUT,
    output logic ASYNC_TMR_EN_OUT,
    output logic MAIN_OSC_EN_OUT,
    output logic SLEEPING_OUT,
    input wire logic [smrc_pkg::PORT_W-1:0] FIRST_PORT_PINS_IN,
    output logic [smrc_pkg::PORT_W-1:0] FIRST_PORT_PINS_OUT,
    output logic [smrc_pkg::PORT_W-1:0] FIRST_PORT_PINS_OE_OUT,
    output logic [smrc_pkg::PORT_W-1:0] FIRST_PORT_PULLUP_OUT,
    input wire logic [smrc_pkg::PORT_W-1:0] SECOND_PORT_PINS_IN,
    output logic [smrc_pkg::PORT_W-1:0] SECOND_PORT_PINS_OUT,
    output logic [smrc_pkg::PORT_W-1:0] SECOND_PORT_PINS_OE_OUT,
    output logic [smrc_pkg::PORT_W-1:0] SECOND_PORT_PULLUP_OUT,
    input wire logic [smrc_pkg::PORT_W-1:0] THIRD_PORT_PINS_IN,
    output logic [smrc_pkg::PORT_W-1:0] THIRD_PORT_PINS_OUT,
    output logic [smrc_pkg::PORT_W-1:0] THIRD_PORT_PINS_OE_OUT,
    output logic [smrc_pkg::PORT_W-1:0] THIRD_PORT_PULLUP_OUT,
    input wire logic [smrc_pkg::PORT_W-1:0] FOURTH_PORT_PINS_IN,
    output logic [smrc_pkg::PORT_W-1:0] FOURTH_PORT_PINS_OUT,
    output logic [smrc_pkg::PORT_W-1:0] FOURTH_PORT_PINS_OE_OUT,
    output logic [smrc_pkg::PORT_W-1:0] FOURTH_PORT_PULLUP_OUT
);
    import smrc_pkg::*;

    // Whole block state and its next value
    smrc_top_st_t st;
    smrc_top_st_t next_st;

    // All four ports packed, lane 0 is the first port
    logic [31:0] pins_in_all;
    logic [31:0] pins_out_all;
    logic [31:0] pins_oe_all;
    logic [31:0] pullup_all;
    logic [31:0] value_all;

    // Bus phase decode
    logic acc_start;
    logic wr_done;
    logic sleep_go;
    logic mode_ok;

    // Gate pattern for a sleep mode; reserved codes never reach here
    function automatic logic [5:0] gate_of(input logic [2:0] m);
        logic [5:0] g;
        g = GATE_RUN;
        case (m)
            MODE_IDLE: g = GATE_IDLE;
            MODE_ADCNR: g = GATE_ADCNR;
            MODE_PDOWN: g = GATE_PDOWN;
            MODE_PSAVE: g = GATE_PSAVE;
            MODE_STBY: g = GATE_STBY;
            MODE_XSTBY: g = GATE_XSTBY;
            default: g = GATE_RUN;
        endcase
        return g;
    endfunction

    // Modes whose wake needs the main oscillator to restart first
    function automatic logic osc_was_off(input logic [2:0] m);
        return (m == MODE_PDOWN) || (m == MODE_PSAVE);
    endfunction

    assign pins_in_all = {FOURTH_PORT_PINS_IN, THIRD_PORT_PINS_IN,
                          SECOND_PORT_PINS_IN, FIRST_PORT_PINS_IN};

    // One port block per 8-bit port
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
        smrc_port u_port (
            .clk_in(SYS_CLK_IN),
            .rst_n_in(RESETN_IN),
            .dir_in(st.dir[g*PORT_W +: PORT_W]),
            .out_in(st.out[g*PORT_W +: PORT_W]),
            .pull_in(st.pull[g*PORT_W +: PORT_W]),
            .pin_in(pins_in_all[g*PORT_W +: PORT_W]),
            .pin_out(pins_out_all[g*PORT_W +: PORT_W]),
            .pin_oe_out(pins_oe_all[g*PORT_W +: PORT_W]),
            .pullup_out(pullup_all[g*PORT_W +: PORT_W]),
            .value_out(value_all[g*PORT_W +: PORT_W])
        );
    end

    // First access cycle: answer is prepared, pready rises next edge
    assign acc_start = PSEL_IN && PENABLE_IN && !st.pready;
    // Completing edge: the only edge at which a write lands
    assign wr_done = PSEL_IN && PENABLE_IN && st.pready && PWRITE_IN;
    // Sleep command strobe
    assign sleep_go = wr_done && (PADDR_IN == OFS_SLEEP_CMD)
                      && PSTRB_IN[0] && PWDATA_IN[CMD_GO_BIT];
    // Only the six defined codes may be entered
    assign mode_ok = (st.mode <= MODE_XSTBY);

    // Next-state logic: bus slave, register writes and sequencer
    always_comb begin
        next_st = st;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;

        // Read data and error are built one cycle ahead of pready
        if (acc_start) begin
            next_st.pready = 1'b1;
            next_st.prdata = '0;
            unique case (PADDR_IN)
                OFS_SLEEP_CTRL: begin
                    next_st.prdata[CTRL_MODE_LSB +: 3] = st.mode;
                    next_st.prdata[CTRL_EN_BIT] = st.sleep_en;
                end
                OFS_SLEEP_CMD: begin
                    // Write-only strobe, reads as zero
                    next_st.prdata = '0;
                end
                OFS_PWR_STATUS: begin
                    next_st.prdata[STAT_GATE_LSB +: 6] = st.gate;
                    next_st.prdata[STAT_STATE_LSB +: 3] = st.state;
                    next_st.prdata[STAT_MODE_LSB +: 3] = st.cur_mode;
                    next_st.prdata[STAT_RSTF_BIT] = st.rst_flag;
                end
                OFS_PORT_DIR: begin
                    next_st.prdata = st.dir;
                end
                OFS_PORT_OUT: begin
                    next_st.prdata = st.out;
                end
                OFS_PORT_PULL: begin
                    next_st.prdata = st.pull;
                end
                OFS_PORT_IN: begin
                    next_st.prdata = value_all;
                end
                default: begin
                    // Unmapped: error answer, data zero, writes dropped
                    next_st.pslverr = 1'b1;
                end
            endcase
        end

        // Register writes, honouring byte strobes
        if (wr_done) begin
            unique case (PADDR_IN)
                OFS_SLEEP_CTRL: begin
                    if (PSTRB_IN[0]) begin
                        next_st.mode = PWDATA_IN[CTRL_MODE_LSB +: 3];
                        next_st.sleep_en = PWDATA_IN[CTRL_EN_BIT];
                    end
                end
                OFS_PWR_STATUS: begin
                    // Reset flag is write-one-to-clear
                    if (PSTRB_IN[2] && PWDATA_IN[STAT_RSTF_BIT]) begin
                        next_st.rst_flag = 1'b0;
                    end
                end
                OFS_PORT_DIR, OFS_PORT_OUT, OFS_PORT_PULL: begin
                    // Lane i belongs to port i, so ports can be set alone
                    for (int i = 0; i < NUM_PORTS; i++) begin
                        if (PSTRB_IN[i]) begin
                            if (PADDR_IN == OFS_PORT_DIR) begin
                                next_st.dir[i*PORT_W +: PORT_W] = PWDATA_IN[i*PORT_W +: PORT_W];
                            end else if (PADDR_IN == OFS_PORT_OUT) begin
                                next_st.out[i*PORT_W +: PORT_W] = PWDATA_IN[i*PORT_W +: PORT_W];
                            end else begin
                                next_st.pull[i*PORT_W +: PORT_W] = PWDATA_IN[i*PORT_W +: PORT_W];
                            end
                        end
                    end
                end
                default: begin
                    // Command strobe, read-only or unmapped: nothing stored
                end
            endcase
        end

        // Power sequencer
        unique case (st.state)
            ST_RUN: begin
                // A wake request in the same cycle cancels the entry,
                // so a wake still asserted in the command cycle keeps the block running
                if (sleep_go && st.sleep_en && mode_ok && !WAKE_IRQ_IN) begin
                    next_st.state = ST_SLEEP;
                    next_st.cur_mode = st.mode;
                    next_st.gate = gate_of(st.mode);
                end
            end
            ST_SLEEP: begin
                // Registers keep their contents while asleep
                if (WAKE_IRQ_IN) begin
                    if (osc_was_off(st.cur_mode)) begin
                        // Oscillator must restart before the CPU runs
                        next_st.state = ST_WAKE;
                        next_st.cnt = OSC_START_CYCLES - 8'h01;
                        next_st.gate = GATE_WAKE;
                    end else begin
                        // Oscillator kept running: resume at once
                        next_st.state = ST_RUN;
                        next_st.gate = GATE_RUN;
                    end
                end
            end
            ST_WAKE: begin
                // Start-up wait, oscillator only
                if (st.cnt == 8'h00) begin
                    next_st.state = ST_RUN;
                    next_st.gate = GATE_RUN;
                end else begin
                    next_st.cnt = st.cnt - 8'h01;
                end
            end
            default: begin
                // Illegal code: restart through the start-up wait
                next_st.state = ST_WAKE;
                next_st.cnt = OSC_START_CYCLES - 8'h01;
                next_st.gate = GATE_WAKE;
            end
        endcase
    end

    // State register; reset acts at once with no clock edge needed
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            st <= '0;
            // CPU held off, oscillator start-up counted after release
            st.state <= ST_WAKE;
            st.cnt <= OSC_START_CYCLES - 8'h01;
            st.gate <= GATE_WAKE;
            st.mode <= CTRL_MODE_RST;
            st.cur_mode <= CTRL_MODE_RST;
            st.rst_flag <= 1'b1;
            st.dir <= PORT_RST;
            st.out <= PORT_RST;
            st.pull <= PORT_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state flip-flops
    assign PRDATA_OUT = st.prdata;
    assign PREADY_OUT = st.pready;
    assign PSLVERR_OUT = st.pslverr;
    assign CPU_CLK_EN_OUT = st.gate[G_CPU];
    assign IO_CLK_EN_OUT = st.gate[G_IO];
    assign INTR_EN_OUT = st.gate[G_INTR];
    assign ADC_CLK_EN_OUT = st.gate[G_ADC];
    assign ASYNC_TMR_EN_OUT = st.gate[G_ASYNC];
    assign MAIN_OSC_EN_OUT = st.gate[G_OSC];
    assign SLEEPING_OUT = st.state[1];

    // Port pins from the port blocks' own flip-flops
    assign FIRST_PORT_PINS_OUT = pins_out_all[7:0];
    assign FIRST_PORT_PINS_OE_OUT = pins_oe_all[7:0];
    assign FIRST_PORT_PULLUP_OUT = pullup_all[7:0];
    assign SECOND_PORT_PINS_OUT = pins_out_all[15:8];
    assign SECOND_PORT_PINS_OE_OUT = pins_oe_all[15:8];
    assign SECOND_PORT_PULLUP_OUT = pullup_all[15:8];
    assign THIRD_PORT_PINS_OUT = pins_out_all[23:16];
    assign THIRD_PORT_PINS_OE_OUT = pins_oe_all[23:16];
    assign THIRD_PORT_PULLUP_OUT = pullup_all[23:16];
    assign FOURTH_PORT_PINS_OUT = pins_out_all[31:24];
    assign FOURTH_PORT_PINS_OE_OUT = pins_oe_all[31:24];
    assign FOURTH_PORT_PULLUP_OUT = pullup_all[31:24];

    // Checks on the sequencer
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    a_sleep_entry: assert property (
        (st.state == ST_RUN && sleep_go && st.sleep_en && mode_ok && !WAKE_IRQ_IN)
        |=> (SLEEPING_OUT && st.cur_mode == $past(st.mode)))
        else $error("sleep command did not enter the chosen mode");
    a_idle_gates: assert property (
        (SLEEPING_OUT && st.cur_mode == MODE_IDLE)
        |-> (!CPU_CLK_EN_OUT && IO_CLK_EN_OUT && INTR_EN_OUT))
        else $error("idle gating wrong");
    a_pdown_wake: assert property (
        (SLEEPING_OUT && st.cur_mode == MODE_PDOWN && WAKE_IRQ_IN)
        |-> ##40 !CPU_CLK_EN_OUT ##1 CPU_CLK_EN_OUT)
        else $error("power-down wake timing wrong");
    a_pdown_off: assert property (
        (SLEEPING_OUT && st.cur_mode == MODE_PDOWN)
        |-> (!MAIN_OSC_EN_OUT && !ASYNC_TMR_EN_OUT && !INTR_EN_OUT && !IO_CLK_EN_OUT))
        else $error("power-down left a function running");
    a_psave_gates: assert property (
        (SLEEPING_OUT && st.cur_mode == MODE_PSAVE)
        |-> (ASYNC_TMR_EN_OUT && !MAIN_OSC_EN_OUT && !CPU_CLK_EN_OUT && !IO_CLK_EN_OUT))
        else $error("power-save gating wrong");
    a_adcnr_gates: assert property (
        (SLEEPING_OUT && st.cur_mode == MODE_ADCNR)
        |-> (ADC_CLK_EN_OUT && ASYNC_TMR_EN_OUT && !IO_CLK_EN_OUT && !CPU_CLK_EN_OUT))
        else $error("adc noise mode gating wrong");
    a_stby_fast: assert property (
        (SLEEPING_OUT && st.cur_mode == MODE_STBY)
        |-> ((MAIN_OSC_EN_OUT && !ASYNC_TMR_EN_OUT && !CPU_CLK_EN_OUT)
            and (WAKE_IRQ_IN |=> CPU_CLK_EN_OUT)))
        else $error("standby gating or wake wrong");
    a_xstby_gates: assert property (
        (SLEEPING_OUT && st.cur_mode == MODE_XSTBY)
        |-> (MAIN_OSC_EN_OUT && ASYNC_TMR_EN_OUT && !CPU_CLK_EN_OUT && !ADC_CLK_EN_OUT))
        else $error("extended standby gating wrong");
    a_reset_hold: assert property (disable iff (1'b0)
        !RESETN_IN |-> (!CPU_CLK_EN_OUT && !SLEEPING_OUT && !PREADY_OUT))
        else $error("reset did not hold the core off");
    a_wake_abort: assert property (
        (st.state == ST_RUN && sleep_go && WAKE_IRQ_IN) |=> !SLEEPING_OUT)
        else $error("sleep entered despite pending wake");

    c_pdown_entry: cover property (SLEEPING_OUT && st.cur_mode == MODE_PDOWN);
    c_stby_wake: cover property (SLEEPING_OUT && st.cur_mode == MODE_STBY && WAKE_IRQ_IN);
    c_bus_error: cover property (PREADY_OUT && PSLVERR_OUT);
    c_port_drive: cover property (FIRST_PORT_PINS_OE_OUT != 8'h00);

endmodule
`default_nettype wire

// ===== logic/smrc_pkg.sv
package smrc_pkg;

    // Bus and data widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int GATE_W = 6;
    localparam int CNT_W = 8;
    localparam int NUM_PORTS = 4;
    localparam int PORT_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_SLEEP_CTRL = 8'h00;
    localparam logic [7:0] OFS_SLEEP_CMD = 8'h04;
    localparam logic [7:0] OFS_PWR_STATUS = 8'h08;
    localparam logic [7:0] OFS_PORT_DIR = 8'h0C;
    localparam logic [7:0] OFS_PORT_OUT = 8'h10;
    localparam logic [7:0] OFS_PORT_PULL = 8'h14;
    localparam logic [7:0] OFS_PORT_IN = 8'h18;

    // Field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_EN_BIT = 3;
    localparam int CMD_GO_BIT = 0;
    localparam int STAT_GATE_LSB = 0;
    localparam int STAT_STATE_LSB = 8;
    localparam int STAT_MODE_LSB = 12;
    localparam int STAT_RSTF_BIT = 16;

    // Gate vector bit positions
    localparam int G_CPU = 0;
    localparam int G_IO = 1;
    localparam int G_INTR = 2;
    localparam int G_ADC = 3;
    localparam int G_ASYNC = 4;
    localparam int G_OSC = 5;

    // Gate patterns per operating condition
    localparam logic [5:0] GATE_RUN = 6'h3F;
    localparam logic [5:0] GATE_IDLE = 6'h3E;
    localparam logic [5:0] GATE_ADCNR = 6'h3C;
    localparam logic [5:0] GATE_PDOWN = 6'h00;
    localparam logic [5:0] GATE_PSAVE = 6'h10;
    localparam logic [5:0] GATE_STBY = 6'h20;
    localparam logic [5:0] GATE_XSTBY = 6'h30;
    localparam logic [5:0] GATE_WAKE = 6'h20;

    // Sleep mode codes; 6 and 7 are reserved
    typedef enum logic [2:0] {
        MODE_IDLE = 3'h0,
        MODE_ADCNR = 3'h1,
        MODE_PDOWN = 3'h2,
        MODE_PSAVE = 3'h3,
        MODE_STBY = 3'h4,
        MODE_XSTBY = 3'h5
    } smrc_mode_t;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAKE = 3'b100
    } smrc_state_t;

    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int OSC_START_NS = 1000;
    localparam logic [7:0] OSC_START_CYCLES =
        8'((OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Reset values
    localparam logic [2:0] CTRL_MODE_RST = 3'h0;
    localparam logic [31:0] PORT_RST = 32'h0000_0000;

    // Port state
    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] val;
        logic [7:0] o;
        logic [7:0] oe;
        logic [7:0] pu;
    } smrc_port_st_t;

    // Sequencer and register state
    typedef struct packed {
        smrc_state_t state;
        logic [2:0] mode;
        logic sleep_en;
        logic [2:0] cur_mode;
        logic [5:0] gate;
        logic [7:0] cnt;
        logic rst_flag;
        logic [31:0] dir;
        logic [31:0] out;
        logic [31:0] pull;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } smrc_top_st_t;

endpackage

// ===== logic/smrc_port.sv
`timescale 1ns/10ps
`default_nettype none
module smrc_port (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] dir_in,
    input wire logic [7:0] out_in,
    input wire logic [7:0] pull_in,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_out,
    output logic [7:0] pullup_out,
    output logic [7:0] value_out
);
    import smrc_pkg::*;

    // Registered port state
    smrc_port_st_t st;
    smrc_port_st_t next_st;

    // Three-stage input capture; a level is taken once stages two and three agree
    always_comb begin
        next_st = st;
        next_st.s1 = pin_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.val = (st.s2 & st.s3) | (st.val & (st.s2 ^ st.s3));
        // Each bit drives or listens on its own
        next_st.oe = dir_in;
        next_st.o = out_in;
        // Pull-up only on bits set as inputs, so a driven pin never fights it
        next_st.pu = pull_in & ~dir_in;
    end

    // Asynchronous clear releases every pin even with no clock running
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pin_out = st.o;
    assign pin_oe_out = st.oe;
    assign pullup_out = st.pu;
    assign value_out = st.val;

    a_reset_tristate: assert property (@(posedge clk_in) disable iff (1'b0)
        !rst_n_in |-> (pin_oe_out == 8'h00 && pullup_out == 8'h00))
        else $error("port drives a pin during reset");
    a_dir_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $past(rst_n_in) |-> (pin_oe_out == $past(dir_in)
            && pullup_out == ($past(pull_in) & ~$past(dir_in))))
        else $error("port enable or pull-up does not follow its setting");

endmodule
`default_nettype wire

// ===== verif/smrc_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module smrc_top_bench;
    import smrc_pkg::*;
    logic clk, rst_n, psel, pen, pwr, wake; // Bench-driven controls
    logic [7:0] paddr;
    logic [31:0] pwdata, pins, rd, dirv;
    logic [3:0] pstrb;
    logic err;
    wire logic [31:0] prdata, pout, poe, ppu; // Ports packed as {fourth, third, second, first}
    wire logic pready, pslverr, sleeping;
    wire logic [5:0] gates; // Same bit order as the gate pattern constants
    int n_errors, n_checks;

    smrc_top DUT (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .WAKE_IRQ_IN(wake),
        .CPU_CLK_EN_OUT(gates[0]), .IO_CLK_EN_OUT(gates[1]), .INTR_EN_OUT(gates[2]),
        .ADC_CLK_EN_OUT(gates[3]), .ASYNC_TMR_EN_OUT(gates[4]), .MAIN_OSC_EN_OUT(gates[5]),
        .SLEEPING_OUT(sleeping), .FIRST_PORT_PINS_IN(pins[7:0]), .FIRST_PORT_PINS_OUT(pout[7:0]),
        .FIRST_PORT_PINS_OE_OUT(poe[7:0]), .FIRST_PORT_PULLUP_OUT(ppu[7:0]),
        .SECOND_PORT_PINS_IN(pins[15:8]), .SECOND_PORT_PINS_OUT(pout[15:8]),
        .SECOND_PORT_PINS_OE_OUT(poe[15:8]), .SECOND_PORT_PULLUP_OUT(ppu[15:8]),
        .THIRD_PORT_PINS_IN(pins[23:16]), .THIRD_PORT_PINS_OUT(pout[23:16]),
        .THIRD_PORT_PINS_OE_OUT(poe[23:16]), .THIRD_PORT_PULLUP_OUT(ppu[23:16]),
        .FOURTH_PORT_PINS_IN(pins[31:24]), .FOURTH_PORT_PINS_OUT(pout[31:24]),
        .FOURTH_PORT_PINS_OE_OUT(poe[31:24]), .FOURTH_PORT_PULLUP_OUT(ppu[31:24]));

    // Single comparison point; case inequality so unknowns never match
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; pready is sampled at the rising edge, the answer is taken
    // at that same edge and only then is the request released
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) chk("pready", 32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // Bounded wait for a gate pattern
    task automatic wait_gates(input logic [5:0] g, input int lim);
        int i;
        for (i = 0; i < lim && gates !== g; i++) @(negedge clk);
        chk("gates", {26'h0, g}, {26'h0, gates});
    endtask

    // Reset state, start-up delay and reset flag
    task automatic t_reset;
        int n;
        chk("oe in reset", 32'h0, poe);
        chk("pullup in reset", 32'h0, ppu);
        chk("gates in reset", {26'h0, GATE_WAKE}, {26'h0, gates});
        @(posedge clk);
        rst_n <= 1'b1;
        for (n = 0; n < 100 && gates[G_CPU] !== 1'b1; n++) @(posedge clk) #1;
        chk("startup edges", 32'd40, 32'(n));
        apb(1'b0, OFS_PWR_STATUS, 32'h0);
        chk("status after reset", 32'h0001_013F, rd);
        apb(1'b1, OFS_PWR_STATUS, 32'h0001_0000);
        apb(1'b0, OFS_PWR_STATUS, 32'h0);
        chk("status flag cleared", 32'h0000_013F, rd);
    endtask

    // Every sleep mode: gates while asleep, wake path and wake duration
    task automatic t_modes;
        logic [5:0] gt [6];
        gt = '{GATE_IDLE, GATE_ADCNR, GATE_PDOWN, GATE_PSAVE, GATE_STBY, GATE_XSTBY};
        for (int m = 0; m < 6; m++) begin
            apb(1'b1, OFS_SLEEP_CTRL, 32'h8 | 32'(m));
            apb(1'b1, OFS_SLEEP_CMD, 32'h1);
            wait_gates(gt[m], 6);
            chk("sleeping", 32'h1, {31'h0, sleeping});
            @(posedge clk);
            wake <= 1'b1;
            @(posedge clk);
            wake <= 1'b0;
            if (m == 2 || m == 3) begin
                wait_gates(GATE_WAKE, 4);
                repeat (30) @(negedge clk);
                chk("oscillator start wait", {26'h0, GATE_WAKE}, {26'h0, gates});
                wait_gates(GATE_RUN, 20);
            end else begin
                wait_gates(GATE_RUN, 4);
            end
        end
    endtask

    // Commands that must not put the block to sleep, and an unmapped address
    task automatic t_refuse;
        logic [31:0] ctl [3];
        ctl = '{32'hE, 32'h2, 32'hA};
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, OFS_SLEEP_CTRL, ctl[k]);
            if (k == 2) wake <= 1'b1;
            apb(1'b1, OFS_SLEEP_CMD, 32'h1);
            repeat (4) @(negedge clk);
            chk("refused sleep", 32'h0, {31'h0, sleeping});
            @(posedge clk);
            wake <= 1'b0;
        end
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        chk("unmapped write error", 32'h1, {31'h0, err});
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped read data", 32'h0, rd);
    endtask

    // Port direction, drive, pull-ups, input path, then an off-edge reset
    task automatic t_ports;
        dirv = 32'h0F0F_00FF;
        apb(1'b1, OFS_PORT_DIR, dirv);
        apb(1'b1, OFS_PORT_OUT, 32'hA5A5_5A5A);
        apb(1'b1, OFS_PORT_PULL, 32'hFFFF_FFFF);
        pins <= 32'h3C96_E1C3;
        repeat (6) @(posedge clk);
        chk("port oe", dirv, poe);
        chk("port drive", 32'hA5A5_5A5A, pout);
        chk("port pullup", ~dirv, ppu);
        apb(1'b0, OFS_PORT_IN, 32'h0);
        chk("port input", 32'h3C96_E1C3 & ~dirv, rd & ~dirv);
        // Lane 1 alone: only the second port's direction may change
        pstrb <= 4'h2;
        apb(1'b1, OFS_PORT_DIR, 32'hFFFF_FFFF);
        pstrb <= 4'hF;
        apb(1'b0, OFS_PORT_DIR, 32'h0);
        chk("port lane write", 32'h0F0F_FFFF, rd);
        // Reset lands just after an edge: the pins must float before the next one
        @(posedge clk);
        rst_n <= 1'b0;
        #2;
        chk("oe async reset", 32'h0, poe);
        chk("pullup async reset", 32'h0, ppu);
        chk("gates async reset", {26'h0, GATE_WAKE}, {26'h0, gates});
        @(posedge clk);
        rst_n <= 1'b1;
        // First edges after the second release: still in start-up, pins released
        repeat (2) @(negedge clk);
        chk("oe after release", 32'h0, poe);
        chk("gates after release", {26'h0, GATE_WAKE}, {26'h0, gates});
    endtask

    // Verdict and end of run
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        {psel, pen, pwr, wake} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        pins = 32'h0;
        repeat (3) @(posedge clk);
        t_reset();
        t_modes();
        t_refuse();
        t_ports();
        conclude();
    end

    // Run is a few hundred cycles; far beyond that means a hang
    initial begin
        #(25 * 20000);
        n_errors++;
        $display("wrong value watchdog expected done seen hang");
        conclude();
    end
endmodule
`default_nettype wire
